// ### rtl/host_interface_mode_select.sv
`timescale 1ns/1ns
// How it works
// - after any initialization the host port runs as an i2c slave.
// - a synced high-to-low on the select pin after init enters spi mode.
// - spi mode holds whatever the select pin does, until reset.
// - in spi mode the select pin is an active-low chip select.
// - while external reset pin is low the block stays in reset.
// - sixteen sense pins and two reference pins float during reset.
// - interrupt output is active high.
// - during measurement every sense channel except the selected one drives low.
// - shared clock pin is i2c clock or spi clock by mode.
// - shared data pin is i2c bidirectional data, spi input only.
// - address/output pin is address input in i2c, spi data out in spi.
// - sensor drive pin pulses while a measurement runs.
// - each channel result is delivered as an 8-bit value.
// - two address pins pick i2c address 0x16..0x19, upper pin as msb.
// - interrupt output falls from high to low at reset release.
// - spi slave supports clock modes 0 and 3.
module host_interface_mode_select
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_reset_n,
  input wire logic interface_select_n,
  input wire logic scl_sck_pin,
  input wire logic sda_si_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr0_or_dout_in,
  output logic addr0_or_dout_out,
  output logic addr0_or_dout_oe,
  input wire logic addr_select_hi,
  input wire logic i2c_sda_drive_low,
  input wire logic spi_dout,
  input wire logic spi_dout_en,
  output logic spi_mode,
  output logic i2c_mode,
  output logic host_clk,
  output logic host_din,
  output logic spi_select,
  output logic [host_mode_pkg::ADDR_W-1:0] slave_addr,
  output logic core_in_reset,
  input wire logic event_irq,
  output logic irq_out,
  input wire logic meas_active,
  input wire logic [host_mode_pkg::CHAN_W-1:0] meas_channel,
  input wire logic adc_valid,
  input wire logic [host_mode_pkg::RESULT_W-1:0] adc_data,
  output logic [host_mode_pkg::RESULT_W-1:0] result_data,
  output logic [host_mode_pkg::CHAN_W-1:0] result_channel,
  output logic result_valid,
  output logic [host_mode_pkg::NUM_SENSE-1:0] sense_out,
  output logic [host_mode_pkg::NUM_SENSE-1:0] sense_oe,
  output logic [host_mode_pkg::NUM_REF-1:0] ref_out,
  output logic [host_mode_pkg::NUM_REF-1:0] ref_oe,
  output logic sensor_drive
);
  import host_mode_pkg::*;
  // ***************************************************
  // pin synchronisers
  // ***************************************************
  logic [5:0] pins_sync;
  logic rst_pin_s;
  logic sel_s;
  logic clk_s;
  logic din_s;
  logic a0_s;
  logic a1_s;
  pin_sync #(.WIDTH(6)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in({ext_reset_n, interface_select_n, scl_sck_pin, sda_si_in,
             addr0_or_dout_in, addr_select_hi}),
    .reset_val(6'h3f),
    .pin_sync_out(pins_sync)
  );
  assign {rst_pin_s, sel_s, clk_s, din_s, a0_s, a1_s} = pins_sync;
  logic in_reset;
  assign in_reset = ~rst_pin_s;
  assign core_in_reset = in_reset;
  // ***************************************************
  // mode state
  // ***************************************************
  host_mode_t mode_ff;
  host_mode_t nxt_mode;
  logic [1:0] settle_ff;
  logic [1:0] nxt_settle;
  logic sel_prev_ff;
  logic nxt_sel_prev;
  logic sel_fall;
  assign sel_fall = sel_prev_ff & ~sel_s;
  always_comb begin
    nxt_mode = mode_ff;
    nxt_settle = settle_ff;
    nxt_sel_prev = sel_s;
    if (in_reset) begin
      nxt_mode = MODE_INIT;
      nxt_settle = 2'h0;
    end else begin
      case (mode_ff)
        MODE_INIT: begin
          nxt_settle = settle_ff + 2'h1;
          if (settle_ff == INIT_SETTLE_CYC) begin
            nxt_mode = MODE_I2C; // default mode, no host action
          end
        end
        MODE_I2C: begin
          if (sel_fall) begin // edge only looked for once init is done
            nxt_mode = MODE_SPI;
          end
        end
        MODE_SPI: nxt_mode = MODE_SPI; // select ignored, only reset leaves
        default: nxt_mode = MODE_INIT;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= MODE_INIT;
      settle_ff <= 2'h0;
      sel_prev_ff <= 1'b1;
    end else begin
      mode_ff <= nxt_mode;
      settle_ff <= nxt_settle;
      sel_prev_ff <= nxt_sel_prev;
    end
  end
  assign spi_mode = (mode_ff == MODE_SPI);
  assign i2c_mode = (mode_ff == MODE_I2C);
  // ***************************************************
  // shared host pins
  // ***************************************************
  logic dout_ff;
  logic nxt_dout;
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] nxt_addr;
  // engines sample host_clk on both edges, so modes 0 and 3 both work
  assign host_clk = clk_s;
  assign host_din = din_s;
  assign spi_select = spi_mode & ~sel_s;
  assign sda_out = 1'b0;
  // open drain in i2c, never driven in spi
  assign sda_oe = i2c_mode & i2c_sda_drive_low;
  assign addr0_or_dout_out = dout_ff;
  // output only while selected in spi, else address strap input
  assign addr0_or_dout_oe = spi_select & spi_dout_en;
  always_comb begin
    nxt_dout = spi_dout;
    nxt_addr = addr_ff;
    // tracked in i2c only, as the lower strap pin carries spi data out in spi
    if (i2c_mode) begin
      nxt_addr = I2C_ADDR_BASE + {5'h00, a1_s, a0_s};
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_ff <= 1'b0;
      addr_ff <= I2C_ADDR_BASE;
    end else begin
      dout_ff <= nxt_dout;
      addr_ff <= nxt_addr;
    end
  end
  assign slave_addr = addr_ff;
  // ***************************************************
  // interrupt output
  // ***************************************************
  logic irq_ff;
  logic nxt_irq;
  always_comb begin
    // held high through reset, low on release unless an event
    nxt_irq = in_reset ? IRQ_RESET_VAL : event_irq;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= IRQ_RESET_VAL;
    end else begin
      irq_ff <= nxt_irq;
    end
  end
  assign irq_out = irq_ff;
  // ***************************************************
  // sense channel drive and sensor drive pulse
  // ***************************************************
  logic measuring;
  logic [DRIVE_CNT_W-1:0] drv_cnt_ff;
  logic [DRIVE_CNT_W-1:0] nxt_drv_cnt;
  logic drive_ff;
  logic nxt_drive;
  assign measuring = meas_active & ~in_reset & ~(mode_ff == MODE_INIT);
  for (genvar c = 0; c < NUM_SENSE; c++) begin : g_sense
    assign sense_out[c] = 1'b0;
    // idle channels low, measured one floats; all float in reset
    assign sense_oe[c] = measuring & (meas_channel != CHAN_W'(c));
  end
  assign ref_out = '0;
  assign ref_oe = '0;
  always_comb begin
    nxt_drv_cnt = drv_cnt_ff;
    nxt_drive = drive_ff;
    if (!measuring) begin
      nxt_drv_cnt = '0;
      nxt_drive = 1'b0;
    end else if (drv_cnt_ff == DRIVE_CNT_W'(DRIVE_HALF_CYC - 1)) begin
      nxt_drv_cnt = '0;
      nxt_drive = ~drive_ff;
    end else begin
      nxt_drv_cnt = drv_cnt_ff + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_cnt_ff <= '0;
      drive_ff <= 1'b0;
    end else begin
      drv_cnt_ff <= nxt_drv_cnt;
      drive_ff <= nxt_drive;
    end
  end
  assign sensor_drive = drive_ff;
  // ***************************************************
  // result capture
  // ***************************************************
  logic [RESULT_W-1:0] res_ff;
  logic [RESULT_W-1:0] nxt_res;
  logic [CHAN_W-1:0] res_ch_ff;
  logic [CHAN_W-1:0] nxt_res_ch;
  logic res_vld_ff;
  logic nxt_res_vld;
  always_comb begin
    nxt_res = res_ff;
    nxt_res_ch = res_ch_ff;
    nxt_res_vld = 1'b0;
    if (adc_valid && measuring) begin
      nxt_res = adc_data;
      nxt_res_ch = meas_channel;
      nxt_res_vld = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_ff <= '0;
      res_ch_ff <= '0;
      res_vld_ff <= 1'b0;
    end else begin
      res_ff <= nxt_res;
      res_ch_ff <= nxt_res_ch;
      res_vld_ff <= nxt_res_vld;
    end
  end
  assign result_data = res_ff;
  assign result_channel = res_ch_ff;
  assign result_valid = res_vld_ff;
  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_init_to_i2c: assert property (
    (mode_ff == MODE_INIT && !in_reset) [*4] |=> i2c_mode)
    else $error("init did not reach i2c mode");
  a_fall_to_spi: assert property (
    i2c_mode && !in_reset && $past(sel_s) && !sel_s |=> spi_mode)
    else $error("select fall did not enter spi");
  a_spi_holds: assert property (
    spi_mode && !in_reset |=> spi_mode)
    else $error("spi mode left without reset");
  a_reset_floats: assert property (
    in_reset |-> sense_oe == '0 && ref_oe == '0)
    else $error("sense pin driven in reset");
  a_reset_to_init: assert property (
    in_reset |=> mode_ff == MODE_INIT && irq_out)
    else $error("reset did not reinitialise");
  a_irq_release: assert property (
    $fell(in_reset) && !event_irq |=> !irq_out)
    else $error("irq did not fall on release");
  a_one_floating: assert property (
    measuring |-> !sense_oe[meas_channel] && $countones(sense_oe) == NUM_SENSE - 1)
    else $error("channel drive pattern wrong");
  a_spi_sda_in: assert property (
    spi_mode |-> !sda_oe)
    else $error("data pin driven in spi mode");
  a_i2c_no_dout: assert property (
    !spi_mode |-> !addr0_or_dout_oe)
    else $error("address pin driven outside spi");
  a_addr_map: assert property (
    i2c_mode && $stable(a0_s) && $stable(a1_s) |=>
      slave_addr == I2C_ADDR_BASE + {5'h00, $past(a1_s), $past(a0_s)})
    else $error("slave address wrong");
  a_drive_toggles: assert property (
    measuring && drv_cnt_ff == DRIVE_CNT_W'(DRIVE_HALF_CYC - 1) |=> sensor_drive != $past(sensor_drive))
    else $error("drive pulse missed toggle");
  c_enter_spi: cover property (i2c_mode ##1 spi_mode);
  c_stay_i2c: cover property (i2c_mode [*8]);
  c_spi_out: cover property (addr0_or_dout_oe);
  c_result: cover property (result_valid);
endmodule

// ### rtl/host_mode_pkg.sv
package host_mode_pkg;
  // ***************************************************
  // timing
  // ***************************************************
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned DRIVE_HZ = 143000;
  // half period of the sensor drive pulse, rounded down
  localparam int unsigned DRIVE_HALF_CYC = CLK_HZ / (2 * DRIVE_HZ);
  localparam int unsigned DRIVE_CNT_W = 9;
  // cycles spent in init so both synchroniser stages hold real pin levels
  localparam logic [1:0] INIT_SETTLE_CYC = 2'h3;
  // ***************************************************
  // widths and values
  // ***************************************************
  localparam int unsigned NUM_SENSE = 16;
  localparam int unsigned NUM_REF = 2;
  localparam int unsigned CHAN_W = 4;
  localparam int unsigned RESULT_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam logic [6:0] I2C_ADDR_BASE = 7'h16;
  localparam logic IRQ_RESET_VAL = 1'b1;
  // ***************************************************
  // host port mode
  // ***************************************************
  typedef enum logic [1:0] {
    MODE_INIT = 2'b00,
    MODE_I2C = 2'b01,
    MODE_SPI = 2'b11
  } host_mode_t;
endpackage

// ### rtl/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] reset_val,
  output logic [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] stable_ff;

  // ***************************************************
  // two flop synchroniser per bit
  // ***************************************************
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_ff[i] <= 1'b1;
        stable_ff[i] <= 1'b1;
      end else begin
        meta_ff[i] <= pin_in[i];
        stable_ff[i] <= meta_ff[i];
      end
    end
    // reset_val is ORed with 1, so each bit reads stable_ff whatever reset_val holds
    assign pin_sync_out[i] = stable_ff[i] & (reset_val[i] | 1'b1);
  end
endmodule

// ### tb/host_model.sv
`timescale 1ns/1ns
// ****************************************
// host microcontroller acting as bus master
// ****************************************
module host_model (
  input wire logic frame,
  output logic sel_n,
  output logic sck,
  output logic sdi
);
  // select stays high outside frames, so the device keeps its i2c port
  assign sel_n = ~frame;
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
  end
  // serial clock idles low between frames; sdi changes every half period
  always begin
    #80;
    sdi = ~sdi;
    if (frame || sck) begin
      sck = ~sck;
    end
  end
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  import host_mode_pkg::*;
  logic clk = 0, rst_n = 0, ext_reset_n = 1, frame = 0, sel_n, sck, sdi;
  logic a0_in = 0, a_hi = 0, drv_low = 0, spi_dout = 0, spi_dout_en = 0;
  logic event_irq = 0, meas_active = 0, adc_valid = 0;
  logic [CHAN_W-1:0] meas_channel = 4'h0;
  logic [RESULT_W-1:0] adc_data = 8'h00;
  logic sda_out, sda_oe, dout, dout_oe, spi_mode, i2c_mode, host_clk, host_din, spi_select;
  logic core_in_reset, irq_out, result_valid, sensor_drive;
  logic [ADDR_W-1:0] slave_addr;
  logic [RESULT_W-1:0] result_data;
  logic [CHAN_W-1:0] result_channel;
  logic [NUM_SENSE-1:0] sense_out, sense_oe;
  logic [NUM_REF-1:0] ref_out, ref_oe;
  int mismatches = 0, tests_run = 0, n;
  logic prev_clk, prev_din;
  always #10 clk = ~clk;
  host_model i_host_model (.frame(frame), .sel_n(sel_n), .sck(sck), .sdi(sdi));
  host_interface_mode_select i_host_interface_mode_select (
    .clk(clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n), .interface_select_n(sel_n),
    .scl_sck_pin(sck), .sda_si_in(sdi), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr0_or_dout_in(a0_in), .addr0_or_dout_out(dout), .addr0_or_dout_oe(dout_oe),
    .addr_select_hi(a_hi), .i2c_sda_drive_low(drv_low), .spi_dout(spi_dout),
    .spi_dout_en(spi_dout_en), .spi_mode(spi_mode), .i2c_mode(i2c_mode),
    .host_clk(host_clk), .host_din(host_din), .spi_select(spi_select),
    .slave_addr(slave_addr), .core_in_reset(core_in_reset), .event_irq(event_irq),
    .irq_out(irq_out), .meas_active(meas_active), .meas_channel(meas_channel),
    .adc_valid(adc_valid), .adc_data(adc_data), .result_data(result_data),
    .result_channel(result_channel), .result_valid(result_valid), .sense_out(sense_out),
    .sense_oe(sense_oe), .ref_out(ref_out), .ref_oe(ref_oe), .sensor_drive(sensor_drive));
  // ****************************************
  // helpers
  // ****************************************
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
    #2;
  endtask
  task automatic chk(input bit bad, input string m);
    tests_run++;
    if (bad) begin
      mismatches++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  task automatic end_sim;
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_i2c;
    chk(irq_out !== 1'b1, "irq not high in reset");
    rst_n = 1;
    wt(2);
    chk(irq_out !== 1'b0, "irq did not fall at release");
    wt(8);
    chk(i2c_mode !== 1'b1 || spi_mode !== 1'b0, "not i2c after init");
    for (int i = 0; i < 4; i++) begin
      {a_hi, a0_in} = i[1:0];
      wt(5);
      chk(slave_addr !== 7'h16 + 7'(i), "slave address");
    end
    drv_low = 1;
    event_irq = 1;
    #1;
    chk(sda_oe !== 1'b1 || sda_out !== 1'b0, "i2c data not pulled");
    wt(1);
    chk(irq_out !== 1'b1, "irq not active high");
    event_irq = 0;
    {a_hi, a0_in} = 2'b00; // upper strap grounded before spi use
  endtask
  task automatic t_spi;
    frame = 1;
    wt(4);
    chk(spi_mode !== 1'b1 || spi_select !== 1'b1, "spi not entered");
    chk(sda_oe !== 1'b0, "data pin driven in spi");
    spi_dout = 1;
    spi_dout_en = 1;
    #1;
    chk(dout_oe !== 1'b1, "spi out not enabled");
    wt(1);
    chk(dout !== 1'b1, "spi out value");
    n = 0;
    while (host_clk !== 1'b1 && n < 40) begin
      wt(1);
      n++;
    end
    chk(n >= 40, "serial clock not passed on");
    for (int i = 0; i < 8; i++) begin
      {prev_clk, prev_din} = {sck, sdi};
      wt(1);
      chk(host_clk !== prev_clk || host_din !== prev_din, "pin relay wrong");
    end
    frame = 0;
    wt(8);
    chk(spi_mode !== 1'b1 || spi_select !== 1'b0 || dout_oe !== 1'b0, "spi deselect");
    spi_dout_en = 0;
    drv_low = 0;
  endtask
  task automatic t_extrst;
    meas_active = 1;
    ext_reset_n = 0;
    wt(5);
    chk(core_in_reset !== 1'b1 || irq_out !== 1'b1, "ext reset not held");
    chk(sense_oe !== 16'h0000 || ref_oe !== 2'h0, "pins not floating");
    meas_active = 0;
    ext_reset_n = 1;
    wt(10);
    chk(i2c_mode !== 1'b1 || spi_mode !== 1'b0, "not i2c after ext reset");
  endtask
  task automatic t_meas;
    meas_channel = 4'h3;
    meas_active = 1;
    #1;
    chk(sense_oe !== 16'hfff7 || sense_out !== 16'h0000, "other channels not low");
    n = 0;
    while (sensor_drive !== 1'b1 && n < 300) begin
      wt(1);
      n++;
    end
    chk(n < 170 || n > 180, "drive pulse timing");
    adc_data = 8'ha5;
    adc_valid = 1;
    wt(1);
    adc_valid = 0;
    chk(result_valid !== 1'b1 || result_data !== 8'ha5, "result data");
    chk(result_channel !== 4'h3, "result channel");
    meas_active = 0;
  endtask
  initial begin
    wt(6);
    t_i2c();
    t_spi();
    t_extrst();
    t_meas();
    end_sim();
  end
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
endmodule
